// [rtl/flash_ctrl_pkg.sv]
// constants and types for the flash self-programming controller
// Behaviour
// [RULE_01] rows hold 64 words, 192 bytes
// [RULE_02] page erase covers eight rows, 512 words
// [RULE_03] pages and rows aligned from address zero
// [RULE_04] 64-word holding buffer loaded within one row
// [RULE_05] target address is page joined to offset
// [RULE_06] low table access covers bits 15 to 0
// [RULE_07] high table access covers bits 23 to 16
// [RULE_08] buffer loads are quick single-word writes
// [RULE_09] 64 load pairs per row, one cycle each
// [RULE_10] start needs keys 55h then AAh consecutively
// [RULE_11] operation lasts 4 ms, processor stalled
// [RULE_12] start bit 15 begins, hardware clears it
// [RULE_13] software can set start, never clear it
// [RULE_14] program enable bit 14 gates operations
// [RULE_15] fault bit 13 set on improper start
// [RULE_16] erase bit 6 picks erase or program
// [RULE_17] erase codes: bulk, segments, page, config byte
// [RULE_18] program codes: word, row, config byte
// [RULE_19] other operation codes do nothing; here they send no array command but still stall for the operation time
// [RULE_20] control bits cleared only by power-on reset
// [RULE_21] key register write-only, reads as zero
// [RULE_22] unused control bits read as zero
// [RULE_23] software erases page before programming a row
// [RULE_24] software follows start with two no-ops
// [RULE_25] intervening write discards partial unlock
// [RULE_26] fault cleared when a proper operation starts
package flash_ctrl_pkg;
    localparam int ROW_WORDS = 64;
    localparam int ROW_BYTES = 192;
    localparam int PAGE_ROWS = 8;
    localparam int PAGE_WORDS = 512;
    localparam int PAGE_BYTES = 1536;
    localparam logic [5:0] ADR_CONTROL = 6'h00;
    localparam logic [5:0] ADR_KEY = 6'h04;
    localparam logic [5:0] ADR_PAGE = 6'h08;
    localparam logic [5:0] ADR_OFFSET = 6'h0C;
    localparam logic [5:0] ADR_STORE_LOW = 6'h10;
    localparam logic [5:0] ADR_STORE_HIGH = 6'h14;
    localparam logic [5:0] ADR_FETCH_LOW = 6'h18;
    localparam logic [5:0] ADR_FETCH_HIGH = 6'h1C;
    localparam logic [5:0] ADR_STATUS = 6'h20;
    localparam int BIT_START = 15;
    localparam int BIT_ENABLE = 14;
    localparam int BIT_FAULT = 13;
    localparam int BIT_ERASE = 6;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [3:0] OP_BULK = 4'hF;
    localparam logic [3:0] OP_SEG_GEN = 4'hD;
    localparam logic [3:0] OP_SEG_SEC = 4'hC;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_CFG = 4'h0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam int CLK_MHZ = 200;
    localparam int OP_TIME_US = 4000;
    localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
    typedef enum logic [3:0] {
        ACT_NONE, ACT_BULK, ACT_SEG_GEN, ACT_SEG_SEC, ACT_PAGE, ACT_CFG_ERASE,
        ACT_WORD, ACT_ROW, ACT_CFG_PROG
    } action_t;
    typedef struct packed {
        logic [23:0] addr;
        action_t action;
        logic go;
    } flash_cmd_t;
    typedef struct packed {
        logic [7:0] high;
        logic [15:0] low;
    } prog_word_t;
endpackage

// [rtl/flash_self_program_ctrl.sv]
// wishbone-attached flash self-programming sequencer
`timescale 1ns/1ps
module flash_self_program_ctrl #(
    parameter int OP_CYCLES_P = flash_ctrl_pkg::OP_CYCLES
) (
    input wire logic sys_clk, // system clock, 200 MHz
    input wire logic sys_rst, // power-on reset, async, high
    input wire logic [5:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic wb_we_i, // write strobe
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o, // acknowledge
    input wire logic [23:0] arrayData, // word read from array at arrayAddr
    input wire logic arrayDone, // array finished early (optional)
    output flash_ctrl_pkg::flash_cmd_t arrayCmd, // command to array
    output logic [23:0] arrayAddr, // array read/target address
    output flash_ctrl_pkg::prog_word_t bufWord, // buffer word at bufIndex
    input wire logic [5:0] bufIndex, // array reads buffer here
    output logic cpuStall // processor held while busy
);
    import flash_ctrl_pkg::*;

    logic [15:0] controlReg, controlNext;
    logic [7:0] pageReg, pageNext;
    logic [15:0] offsetReg, offsetNext;
    logic keyArmedReg, keyArmedNext;
    logic keyFirstReg, keyFirstNext;
    logic busyReg, busyNext;
    logic [31:0] timerReg, timerNext;
    logic ackReg, ackNext;
    logic [31:0] rdReg, rdNext;
    flash_cmd_t cmdReg, cmdNext;
    prog_word_t buffer [ROW_WORDS];
    prog_word_t bufWordReg;
    logic [23:0] arrayAddrReg;
    logic [31:0] rdData;

    // decode of the operation field against erase/program
    function automatic action_t decode(input logic erase, input logic [3:0] op);
        action_t a;
        a = ACT_NONE;
        if (erase) begin // see [RULE_16]
            unique case (op) // see [RULE_17]
                OP_BULK: a = ACT_BULK;
                OP_SEG_GEN: a = ACT_SEG_GEN;
                OP_SEG_SEC: a = ACT_SEG_SEC;
                OP_PAGE: a = ACT_PAGE;
                OP_CFG: a = ACT_CFG_ERASE;
                default: a = ACT_NONE; // see [RULE_19]
            endcase
        end else begin
            unique case (op) // see [RULE_18]
                OP_WORD: a = ACT_WORD;
                OP_ROW: a = ACT_ROW;
                OP_CFG: a = ACT_CFG_PROG;
                default: a = ACT_NONE; // see [RULE_19]
            endcase
        end
        return a;
    endfunction

    // align target to page, row or word start, counted from zero
    function automatic logic [23:0] align(input action_t a, input logic [23:0] addr);
        logic [23:0] wordIdx;
        wordIdx = {1'b0, addr[23:1]};
        if (a == ACT_PAGE) begin // see [RULE_03]
            align = {addr[23:10], 10'h000}; // see [RULE_02]
        end else if (a == ACT_ROW) begin
            align = {addr[23:7], 7'h00}; // see [RULE_01]
        end else begin
            align = {wordIdx[22:0], 1'b0};
        end
    endfunction

    wire access = wb_cyc_i && wb_stb_i && !ackReg;
    wire wr = access && wb_we_i;
    wire [23:0] target = {pageReg, offsetReg}; // see [RULE_05]
    wire [5:0] slot = offsetReg[6:1]; // see [RULE_04]

    // read multiplexer
    always_comb begin
        rdData = 32'h0000_0000;
        unique case (wb_adr_i)
            ADR_CONTROL: rdData = {16'h0000, controlReg}; // see [RULE_22]
            ADR_KEY: rdData = 32'h0000_0000; // see [RULE_21]
            ADR_PAGE: rdData = {24'h000000, pageReg};
            ADR_OFFSET: rdData = {16'h0000, offsetReg};
            ADR_FETCH_LOW: rdData = {16'h0000, arrayData[15:0]}; // see [RULE_06]
            ADR_FETCH_HIGH: rdData = {24'h000000, arrayData[23:16]}; // see [RULE_07]
            ADR_STATUS: rdData = {31'h0, busyReg};
            default: rdData = 32'h0000_0000;
        endcase
    end

    // register, unlock and sequencer next state
    always_comb begin
        logic [15:0] w;
        action_t act;
        w = wb_dat_i[15:0];
        act = ACT_NONE;
        controlNext = controlReg;
        pageNext = pageReg;
        offsetNext = offsetReg;
        keyArmedNext = keyArmedReg;
        keyFirstNext = keyFirstReg;
        busyNext = busyReg;
        timerNext = timerReg;
        ackNext = access; // one wait state, dropped next cycle
        rdNext = access ? rdData : rdReg;
        cmdNext = cmdReg;
        cmdNext.go = 1'b0;
        if (busyReg) begin
            // bus writes are still acked but the cpu is stalled
            if (timerReg == 32'd1 || arrayDone) begin
                busyNext = 1'b0;
                controlNext[BIT_START] = 1'b0; // see [RULE_12]
            end
            timerNext = timerReg - 32'd1;
        end else if (wr) begin
            // any write other than the second key breaks the unlock
            keyFirstNext = 1'b0; // see [RULE_25]
            if (wb_adr_i != ADR_CONTROL) begin
                keyArmedNext = 1'b0;
            end
            unique case (wb_adr_i)
                ADR_KEY: if (wb_sel_i[0]) begin
                    if (wb_dat_i[7:0] == KEY_FIRST) begin // see [RULE_10]
                        keyFirstNext = 1'b1;
                    end else if (keyFirstReg && wb_dat_i[7:0] == KEY_SECOND) begin
                        keyArmedNext = 1'b1;
                    end
                end
                ADR_PAGE: if (wb_sel_i[0]) pageNext = wb_dat_i[7:0];
                ADR_OFFSET: begin
                    if (wb_sel_i[0]) offsetNext[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) offsetNext[15:8] = wb_dat_i[15:8];
                end
                ADR_CONTROL: begin
                    if (wb_sel_i[0]) begin
                        controlNext[BIT_ERASE] = w[BIT_ERASE];
                        controlNext[3:0] = w[3:0];
                    end
                    if (wb_sel_i[1]) begin
                        controlNext[BIT_ENABLE] = w[BIT_ENABLE];
                        controlNext[BIT_FAULT] = w[BIT_FAULT];
                        keyArmedNext = 1'b0;
                        if (w[BIT_START]) begin // see [RULE_13]
                            act = decode(wb_sel_i[0] ? w[BIT_ERASE] : controlReg[BIT_ERASE],
                                wb_sel_i[0] ? w[3:0] : controlReg[3:0]);
                            if (keyArmedReg && w[BIT_ENABLE]) begin // see [RULE_14]
                                controlNext[BIT_START] = 1'b1;
                                controlNext[BIT_FAULT] = 1'b0; // see [RULE_26]
                                busyNext = 1'b1;
                                timerNext = 32'(OP_CYCLES_P); // see [RULE_11]
                                cmdNext.go = (act != ACT_NONE);
                                cmdNext.action = act;
                                cmdNext.addr = align(act, target);
                            end else begin
                                controlNext[BIT_FAULT] = 1'b1; // see [RULE_15]
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // holding buffer loads, single-cycle writes
    always_ff @(posedge sys_clk) begin
        if (wr && !busyReg && wb_adr_i == ADR_STORE_LOW) begin // see [RULE_08]
            if (wb_sel_i[0]) buffer[slot].low[7:0] <= wb_dat_i[7:0]; // see [RULE_06]
            if (wb_sel_i[1]) buffer[slot].low[15:8] <= wb_dat_i[15:8];
        end
        if (wr && !busyReg && wb_adr_i == ADR_STORE_HIGH && wb_sel_i[0]) begin
            buffer[slot].high <= wb_dat_i[7:0]; // see [RULE_07] [RULE_09]
        end
        bufWordReg <= buffer[bufIndex];
        arrayAddrReg <= busyReg ? cmdReg.addr : target;
    end

    // control state, cleared only by power-on reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            controlReg <= CONTROL_RESET; // see [RULE_20]
            pageReg <= 8'h00;
            offsetReg <= 16'h0000;
            keyArmedReg <= 1'b0;
            keyFirstReg <= 1'b0;
            busyReg <= 1'b0;
            timerReg <= 32'h0000_0000;
            ackReg <= 1'b0;
            rdReg <= 32'h0000_0000;
            cmdReg <= '0;
        end else begin
            controlReg <= controlNext;
            pageReg <= pageNext;
            offsetReg <= offsetNext;
            keyArmedReg <= keyArmedNext;
            keyFirstReg <= keyFirstNext;
            busyReg <= busyNext;
            timerReg <= timerNext;
            ackReg <= ackNext;
            rdReg <= rdNext;
            cmdReg <= cmdNext;
        end
    end

    assign wb_ack_o = ackReg;
    assign wb_dat_o = rdReg;
    assign arrayCmd = cmdReg;
    assign arrayAddr = arrayAddrReg;
    assign bufWord = bufWordReg;
    assign cpuStall = busyReg; // see [RULE_11]
endmodule

// [tb/flash_self_program_ctrl_chk.sv]
// port-level checker for the flash self-programming controller
`timescale 1ns/1ps
module flash_self_program_ctrl_chk
    import flash_ctrl_pkg::*;
#(
    parameter int OP_CYCLES_P = 20
) (
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // async reset
    input wire logic [5:0] wb_adr_i, // address
    input wire logic wb_we_i, // direction
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // answer
    input wire logic [31:0] wb_dat_o, // read data
    input wire flash_ctrl_pkg::flash_cmd_t arrayCmd, // array command
    input wire logic cpuStall // busy stall
);
    logic [31:0] stallCnt_reg;
    logic [31:0] stallCnt_next;
    logic rdTaken;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // stall length counter, restarts whenever the stall drops
    always_comb begin
        stallCnt_next = cpuStall ? stallCnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stallCnt_reg <= 32'h0;
        end else begin
            stallCnt_reg <= stallCnt_next;
        end
    end
    assign rdTaken = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_key_reads_zero: assert property (rdTaken && wb_adr_i == ADR_KEY |=> wb_dat_o == 32'h0)
        else $error("key read not zero");
    a_ctrl_unused_zero: assert property (rdTaken && wb_adr_i == ADR_CONTROL |=>
        wb_dat_o[12:7] == 6'h0 && wb_dat_o[5:4] == 2'h0 && wb_dat_o[31:16] == 16'h0) else $error("unused bits set");
    a_go_pulse: assert property (arrayCmd.go |=> !arrayCmd.go) else $error("go held");
    a_go_defined: assert property (arrayCmd.go |-> arrayCmd.action != ACT_NONE)
        else $error("go without action");
    a_go_stalls: assert property (arrayCmd.go |-> ##[0:1] cpuStall) else $error("go without stall");
    a_stall_length: assert property ($fell(cpuStall) |-> stallCnt_reg >= 32'(OP_CYCLES_P)
        && stallCnt_reg <= 32'(OP_CYCLES_P + 1)) else $error("stall length wrong");
endmodule
bind flash_self_program_ctrl flash_self_program_ctrl_chk #(.OP_CYCLES_P(OP_CYCLES_P)) i_flash_self_program_ctrl_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .arrayCmd(arrayCmd), .cpuStall(cpuStall));

// [tb/tb_flash_self_program_ctrl.sv]
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module tb_flash_self_program_ctrl;
    import flash_ctrl_pkg::*;
    localparam int OPC = 20; // short op time keeps the run brief
    logic sys_clk = 1'b0, sys_rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, stall;
    logic [5:0] adr = 6'h00, bufIdx = 6'h00;
    logic [31:0] dat = 32'h0, datO, q;
    logic [23:0] arrData = 24'hABCDEF, arrAddr;
    flash_cmd_t cmd;
    prog_word_t bWord;
    action_t lastAct = ACT_NONE;
    logic [23:0] lastAddr = 24'h000000;
    int n_fail = 0, num_checks = 0, goCnt = 0;
    always #2.5 sys_clk = ~sys_clk;
    // record array commands so each run is judged after it ends
    always @(posedge sys_clk) begin
        if (cmd.go === 1'b1) begin
            goCnt <= goCnt + 1;
            lastAct <= cmd.action;
            lastAddr <= cmd.addr;
        end
    end
    flash_self_program_ctrl #(.OP_CYCLES_P(OPC)) i_flash_self_program_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(datO), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .arrayData(arrData), .arrayDone(1'b0), .arrayCmd(cmd),
        .arrayAddr(arrAddr), .bufWord(bWord), .bufIndex(bufIdx), .cpuStall(stall));
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one classic cycle; request held until ack is seen at an edge
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        adr <= a; we <= w; dat <= d; cyc <= 1'b1; stb <= 1'b1;
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = datO;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    function automatic action_t exp_act(input logic e, input logic [3:0] op);
        if (e) return op == 4'hF ? ACT_BULK : op == 4'hD ? ACT_SEG_GEN : op == 4'hC ? ACT_SEG_SEC :
            op == 4'h2 ? ACT_PAGE : op == 4'h0 ? ACT_CFG_ERASE : ACT_NONE;
        return op == 4'h3 ? ACT_WORD : op == 4'h1 ? ACT_ROW : op == 4'h0 ? ACT_CFG_PROG : ACT_NONE;
    endfunction
    task automatic t_regs();
        wb(0, ADR_CONTROL, 0); chk(q, 0);
        wb(1, ADR_KEY, 32'h55); wb(0, ADR_KEY, 0); chk(q, 0);
        wb(1, 6'h3C, 32'hFFFF); wb(0, 6'h3C, 0); chk(q, 0);
        wb(1, ADR_CONTROL, 32'h3FFF); wb(0, ADR_CONTROL, 0); chk(q, 32'h204F);
    endtask
    task automatic t_buf();
        wb(1, ADR_PAGE, 32'h12); wb(1, ADR_OFFSET, 32'h6);
        wb(1, ADR_STORE_LOW, 32'h1234); wb(1, ADR_STORE_HIGH, 32'h56);
        bufIdx <= 6'h03;
        repeat (2) @(posedge sys_clk);
        chk({8'h0, arrAddr}, 32'h120006);
        chk({8'h0, bWord}, 32'h561234);
        wb(0, ADR_FETCH_LOW, 0); chk(q, 32'hCDEF);
        wb(0, ADR_FETCH_HIGH, 0); chk(q, 32'hAB);
    endtask
    // improper starts must neither stall nor leave the fault clear
    task automatic t_bad(input logic mid, input logic [5:0] ma, input logic [15:0] sv);
        wb(1, ADR_CONTROL, {16'h0, sv & 16'h7FFF}); wb(1, ADR_KEY, 32'h55);
        if (mid) wb(1, ma, 0);
        wb(1, ADR_KEY, 32'hAA); wb(1, ADR_CONTROL, {16'h0, sv});
        repeat (3) @(posedge sys_clk);
        chk(32'(stall), 0);
        wb(0, ADR_CONTROL, 0); chk(q, {16'h0, (sv & 16'h7FFF) | 16'h2000});
    endtask
    task automatic t_run(input logic e, input logic [3:0] op);
        logic [15:0] c;
        action_t x;
        int g0;
        c = {9'h080, e, 2'h0, op};
        x = exp_act(e, op);
        g0 = goCnt;
        wb(1, ADR_OFFSET, 32'hABC);
        wb(1, ADR_CONTROL, {16'h0, c}); wb(1, ADR_KEY, 32'h55); wb(1, ADR_KEY, 32'hAA);
        wb(1, ADR_CONTROL, {16'h0, c | 16'h8000});
        repeat (2) @(posedge sys_clk); // two quiet cycles after start
        chk(32'(stall), 1);
        for (int i = 0; i < 200 && stall !== 1'b0; i++) @(posedge sys_clk);
        wb(0, ADR_CONTROL, 0); chk(q, {16'h0, c});
        chk(32'(goCnt - g0), x == ACT_NONE ? 0 : 1);
        if (x != ACT_NONE) chk(32'(lastAct), 32'(x));
        if (x != ACT_NONE) chk({8'h0, lastAddr}, x == ACT_PAGE ? 32'h800 : x == ACT_ROW ? 32'hA80 : 32'hABC);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_buf();
        t_bad(1, ADR_PAGE, 16'hC042);
        t_bad(1, ADR_KEY, 16'hC042);
        t_bad(0, ADR_KEY, 16'h8042);
        // erase codes run before program codes
        for (int e = 1; e >= 0; e--) for (int op = 0; op < 16; op++) t_run(e[0], op[3:0]);
        report_and_stop();
    end
endmodule
